// [logic/tc16_timer.sv]
// Purpose: 16-bit up counter with timer, event counter and window modes, AHB-Lite registers.
// Assumes: Single word transfers; counter_input_pin is synchronous-capable but is resynchronised.
// Notes: Reads insert one wait state; writes complete with none.
//
// Summary of operation
// - A lone byte write to the compare register has no effect, except a high byte write in the warm-up setting.
// - Old compare value stays in use until the high byte lands.
// - Control bits 7, 6 and 1 read back undefined; here zero.
// - Stop power mode clears the run bit and halts counting.
// - Three modes: internal timer, external event counter, pin-gated window.
// - Timer mode counts selected clock, matches, interrupts, clears, continues.
// - Fast clock in slow state with fast oscillator: match upper five bits.
// - Only the fast clock in timer mode, in the slow state with fast oscillator, times oscillator warm-up.
// - Clock codes 000-101; slow states lose 010, 011, 101; 100 only in the slow state with fast oscillator.
// - Event mode counts each rising pin edge, also after a clear.
// - Event mode checks the match on the falling pin edge.
// - Window mode counts internal clock while pin is high; match clears.
`timescale 1ns/1ps
`default_nettype none
module tc16_timer
	import tc16_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic stop_mode_req,
	input wire logic counter_input_pin,
	output logic compare_match_irq
);
	////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic power_type pwr_decode(input logic [1:0] code);
		case (code)
			PWR_CODE_NORMAL: pwr_decode = ST_NORMAL;
			PWR_CODE_SLOW_OFF: pwr_decode = ST_SLOW_OFF;
			PWR_CODE_SLOW_ON: pwr_decode = ST_SLOW_ON;
			PWR_CODE_SLEEP: pwr_decode = ST_SLEEP;
			default: pwr_decode = ST_NORMAL;
		endcase
	endfunction

	// Codes not offered in a state give no tick at all
	function automatic logic src_tick(input logic [2:0] ck, input power_type pwr, input logic tap,
		input tick_type t);
		src_tick = 1'b0;
		case (pwr)
			ST_NORMAL:
				case (ck)
					CK_DIV11: src_tick = tap ? t.lf_3 : t.hf_11;
					CK_DIV7: src_tick = t.hf_7;
					CK_DIV5: src_tick = t.hf_5;
					CK_DIV3: src_tick = t.hf_3;
					CK_LF: src_tick = t.lf;
					default: src_tick = 1'b0;
				endcase
			ST_SLOW_OFF, ST_SLEEP:
				case (ck)
					CK_DIV11: src_tick = t.lf_3;
					CK_DIV7: src_tick = t.lf_5;
					default: src_tick = 1'b0;
				endcase
			ST_SLOW_ON:
				case (ck)
					CK_DIV11: src_tick = t.lf_3;
					CK_DIV7: src_tick = t.lf_5;
					CK_HF: src_tick = 1'b1;
					default: src_tick = 1'b0;
				endcase
			default: src_tick = 1'b0;
		endcase
	endfunction

	function automatic logic is_match(input logic [15:0] a, input logic [15:0] b, input logic warm);
		if (warm)
			is_match = (a[15:WARM_LSB] == b[15:WARM_LSB]);
		else
			is_match = (a == b);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave

	bus_req_type req_r;
	logic rd_wait_r;
	logic [31:0] hrdata_r;
	logic run_r;
	logic [2:0] cksel_r;
	logic win_mode_r;
	logic [1:0] pwr_code_r;
	logic tap_r;
	logic [15:0] cmp_r;
	logic [7:0] low_buf_r;
	logic low_pend_r;
	logic [15:0] cnt_r;
	logic irq_r;

	wire logic take = hsel & hready & htrans[1];
	wire logic wr_en = req_r.valid & req_r.write & hready;
	wire logic wr_ctrl = wr_en & (req_r.addr == CTRL_ADDR);
	wire logic wr_lo = wr_en & (req_r.addr == CMP_LO_ADDR);
	wire logic wr_hi = wr_en & (req_r.addr == CMP_HI_ADDR);
	wire logic wr_pwr = wr_en & (req_r.addr == PWR_ADDR);

	// Unmapped offsets read as zero
	wire logic [31:0] rd_mux =
		(req_r.addr == CTRL_ADDR) ? {24'h000000, 2'h0, run_r, cksel_r, 1'b0, win_mode_r} :
		(req_r.addr == CMP_LO_ADDR) ? {24'h000000, cmp_r[7:0]} :
		(req_r.addr == CMP_HI_ADDR) ? {24'h000000, cmp_r[15:8]} :
		(req_r.addr == COUNT_ADDR) ? {16'h0000, cnt_r} :
		(req_r.addr == PWR_ADDR) ? {29'h00000000, tap_r, pwr_code_r} : 32'h00000000;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			req_r <= '0;
			rd_wait_r <= 1'b0;
			hrdata_r <= 32'h00000000;
		end
		else
		begin
			if (hready)
			begin
				req_r.addr <= haddr[7:0];
				req_r.write <= hwrite;
				req_r.valid <= take;
			end
			rd_wait_r <= take & ~hwrite;
			if (rd_wait_r)
				hrdata_r <= rd_mux;
		end
	end

	// One wait state so read data comes from a flop and sees the latest write
	assign hreadyout = ~rd_wait_r;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;

	////////////////////////////////////////////////////////////////////////////
	// Control and configuration

	// Stop mode overrides a software start in the same cycle
	wire logic run_nxt = stop_mode_req ? 1'b0 : (wr_ctrl ? hwdata[RUN_BIT] : run_r);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			run_r <= 1'b0;
			cksel_r <= CK_DIV11;
			win_mode_r <= 1'b0;
			pwr_code_r <= PWR_CODE_NORMAL;
			tap_r <= 1'b0;
		end
		else
		begin
			run_r <= run_nxt;
			if (wr_ctrl)
			begin
				cksel_r <= hwdata[CKSEL_MSB:CKSEL_LSB];
				win_mode_r <= hwdata[WIN_BIT];
			end
			if (wr_pwr)
			begin
				pwr_code_r <= hwdata[PWR_MSB:PWR_LSB];
				tap_r <= hwdata[TAP_BIT];
			end
		end
	end

	mode_type mode;
	power_type pwr;
	tick_type ticks;
	assign mode = win_mode_r ? MODE_WINDOW : ((cksel_r == CK_PIN) ? MODE_EVENT : MODE_TIMER);
	assign pwr = pwr_decode(pwr_code_r);

	clock_tap_gen u_taps (
		.hclk(hclk),
		.hresetn(hresetn),
		.ticks(ticks)
	);

	wire logic src = src_tick(cksel_r, pwr, tap_r, ticks);
	wire logic warm = (mode == MODE_TIMER) & (pwr == ST_SLOW_ON) & (cksel_r == CK_HF);

	////////////////////////////////////////////////////////////////////////////
	// Compare register with low-then-high loading

	// Low byte is parked until the high byte commits both together
	wire logic [15:0] cmp_nxt =
		(wr_hi & low_pend_r) ? {hwdata[7:0], low_buf_r} :
		(wr_hi & warm) ? {hwdata[7:0], cmp_r[7:0]} : cmp_r;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cmp_r <= CMP_RESET;
			low_buf_r <= 8'h00;
			low_pend_r <= 1'b0;
		end
		else
		begin
			cmp_r <= cmp_nxt;
			if (wr_lo)
			begin
				low_buf_r <= hwdata[7:0];
				low_pend_r <= 1'b1;
			end
			else if (wr_hi)
				low_pend_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin synchroniser and edge detection

	logic pin_s1_r;
	logic pin_s2_r;
	logic pin_d_r;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin_s1_r <= 1'b0;
			pin_s2_r <= 1'b0;
			pin_d_r <= 1'b0;
		end
		else
		begin
			pin_s1_r <= counter_input_pin;
			pin_s2_r <= pin_s1_r;
			pin_d_r <= pin_s2_r;
		end
	end

	wire logic pin_rise = pin_s2_r & ~pin_d_r;
	wire logic pin_fall = ~pin_s2_r & pin_d_r;

	////////////////////////////////////////////////////////////////////////////
	// Up counter

	wire logic [15:0] cnt_inc = cnt_r + 16'h0001;
	logic [15:0] cnt_nxt;
	logic hit;

	always_comb
	begin
		cnt_nxt = cnt_r;
		hit = 1'b0;
		if (!run_r)
			cnt_nxt = 16'h0000;
		else
			case (mode)
				MODE_TIMER:
					if (src)
					begin
						if (is_match(cnt_inc, cmp_r, warm))
						begin
							hit = 1'b1;
							cnt_nxt = 16'h0000;
						end
						else
							cnt_nxt = cnt_inc;
					end
				MODE_EVENT:
					if (pin_fall & is_match(cnt_r, cmp_r, 1'b0))
					begin
						hit = 1'b1;
						cnt_nxt = 16'h0000;
					end
					else if (pin_rise)
						cnt_nxt = cnt_inc;
				MODE_WINDOW:
					if (src & pin_s2_r)
					begin
						if (is_match(cnt_inc, cmp_r, 1'b0))
						begin
							hit = 1'b1;
							cnt_nxt = 16'h0000;
						end
						else
							cnt_nxt = cnt_inc;
					end
				default: cnt_nxt = 16'h0000;
			endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cnt_r <= 16'h0000;
			irq_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			irq_r <= hit;
		end
	end

	assign compare_match_irq = irq_r;

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	ctrl_read_zero_a: assert property ((rd_wait_r && req_r.addr == CTRL_ADDR) |=>
		(hrdata[7:6] == 2'h0 && hrdata[1] == 1'b0 && hreadyout))
		else $error("control read shows undefined bits set");

	stop_clears_run_a: assert property (stop_mode_req |=> (!run_r ##1 cnt_r == 16'h0000))
		else $error("stop mode did not halt the counter");

	lone_byte_ignored_a: assert property ((wr_hi && !low_pend_r && !warm) |=> $stable(cmp_r))
		else $error("lone high byte write changed compare");

	old_cmp_kept_a: assert property (wr_lo |=> (cmp_r == $past(cmp_r) && low_pend_r))
		else $error("compare changed on low byte write");

	pair_commit_a: assert property ((wr_hi && low_pend_r) |=>
		(cmp_r == {$past(hwdata[7:0]), $past(low_buf_r)}))
		else $error("compare pair did not commit");

	timer_wrap_a: assert property ((run_r && mode == MODE_TIMER && src && !warm && cnt_inc == cmp_r) |=>
		(cnt_r == 16'h0000 && compare_match_irq))
		else $error("timer match did not clear and interrupt");

	warm_match_a: assert property ((run_r && warm && src && cnt_inc[15:11] == cmp_r[15:11]) |=>
		compare_match_irq)
		else $error("warm-up match on upper bits missed");

	slow_codes_a: assert property ((pwr != ST_NORMAL && (cksel_r == CK_DIV5 || cksel_r == CK_DIV3 ||
		cksel_r == CK_LF || (cksel_r == CK_HF && pwr != ST_SLOW_ON))) |-> !src)
		else $error("unavailable source clock ticked");

	event_rise_a: assert property ((run_r && mode == MODE_EVENT && pin_rise && run_nxt) |=>
		cnt_r == $past(cnt_inc))
		else $error("event edge not counted");

	event_fall_a: assert property ((run_r && mode == MODE_EVENT && !pin_fall) |=> !compare_match_irq)
		else $error("event match raised off a falling edge");

	window_gate_a: assert property ((run_r && run_nxt && mode == MODE_WINDOW && !pin_s2_r) |=>
		$stable(cnt_r))
		else $error("window counted with pin low");

	stopped_zero_a: assert property (!run_r |=> cnt_r == 16'h0000)
		else $error("stopped counter not zero");

	single_edge_a: assert property (pin_rise |-> ($past(counter_input_pin, 2) && !$past(counter_input_pin, 3)))
		else $error("pin rise not traced to one synchronised edge");
endmodule // tc16_timer
`default_nettype wire

// [logic/tc16_pkg.sv]
// Purpose: Shared constants and types for the 16-bit timer/event/window counter.
// Assumes: hclk is the high-frequency clock; the low-frequency clock is a tick derived from it.
// Notes: Register offsets are byte addresses on the AHB-Lite bus.
`default_nettype none
package tc16_pkg;
	// Register byte offsets
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] CMP_LO_ADDR = 8'h04;
	localparam logic [7:0] CMP_HI_ADDR = 8'h08;
	localparam logic [7:0] COUNT_ADDR = 8'h0C;
	localparam logic [7:0] PWR_ADDR = 8'h10;
	// Control register fields
	localparam int RUN_BIT = 5;
	localparam int CKSEL_LSB = 2;
	localparam int CKSEL_MSB = 4;
	localparam int WIN_BIT = 0;
	// Power state register fields
	localparam int PWR_LSB = 0;
	localparam int PWR_MSB = 1;
	localparam int TAP_BIT = 2;
	localparam logic [1:0] PWR_CODE_NORMAL = 2'h0;
	localparam logic [1:0] PWR_CODE_SLOW_OFF = 2'h1;
	localparam logic [1:0] PWR_CODE_SLOW_ON = 2'h2;
	localparam logic [1:0] PWR_CODE_SLEEP = 2'h3;
	// Source clock select codes
	localparam logic [2:0] CK_DIV11 = 3'h0;
	localparam logic [2:0] CK_DIV7 = 3'h1;
	localparam logic [2:0] CK_DIV5 = 3'h2;
	localparam logic [2:0] CK_DIV3 = 3'h3;
	localparam logic [2:0] CK_HF = 3'h4;
	localparam logic [2:0] CK_LF = 3'h5;
	localparam logic [2:0] CK_PIN = 3'h7;
	// Warm-up compare ignores bits below this one
	localparam int WARM_LSB = 11;
	localparam logic [15:0] CMP_RESET = 16'hFFFF;
	// Low-frequency tick: hclk cycles per tick, minus one
	localparam logic [9:0] LF_DIV_LAST = 10'h261;
	typedef enum logic [2:0] {
		MODE_TIMER = 3'b001,
		MODE_EVENT = 3'b010,
		MODE_WINDOW = 3'b100
	} mode_type;
	typedef enum logic [3:0] {
		ST_NORMAL = 4'b0001,
		ST_SLOW_OFF = 4'b0010,
		ST_SLOW_ON = 4'b0100,
		ST_SLEEP = 4'b1000
	} power_type;
	typedef struct packed {
		logic [7:0] addr;
		logic write;
		logic valid;
	} bus_req_type;
	typedef struct packed {
		logic hf_3;
		logic hf_5;
		logic hf_7;
		logic hf_11;
		logic lf;
		logic lf_3;
		logic lf_5;
	} tick_type;
endpackage
`default_nettype wire

// [logic/clock_tap_gen.sv]
// Purpose: Prescaler producing one-cycle ticks at the divided source clock rates.
// Assumes: hclk stands for the high-frequency clock.
// Notes: Each tick is high for one hclk cycle per period.
`timescale 1ns/1ps
`default_nettype none
module clock_tap_gen
	import tc16_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	output tick_type ticks
);
	logic [10:0] hf_cnt_r;
	logic [9:0] lf_div_r;
	logic [4:0] lf_cnt_r;
	wire logic lf_wrap = (lf_div_r == LF_DIV_LAST);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hf_cnt_r <= 11'h000;
			lf_div_r <= 10'h000;
			lf_cnt_r <= 5'h00;
		end
		else
		begin
			hf_cnt_r <= hf_cnt_r + 11'h001;
			lf_div_r <= lf_wrap ? 10'h000 : lf_div_r + 10'h001;
			if (lf_wrap)
				lf_cnt_r <= lf_cnt_r + 5'h01;
		end
	end

	// A tap fires when all bits below it are ones
	wire logic hf_3 = &hf_cnt_r[2:0];
	wire logic hf_5 = &hf_cnt_r[4:0];
	wire logic hf_7 = &hf_cnt_r[6:0];
	wire logic hf_11 = &hf_cnt_r[10:0];
	wire logic lf_3 = lf_wrap & (&lf_cnt_r[2:0]);
	wire logic lf_5 = lf_wrap & (&lf_cnt_r[4:0]);
	// One assignment keeps the struct variable single-driven
	assign ticks = {hf_3, hf_5, hf_7, hf_11, lf_wrap, lf_3, lf_5};
endmodule // clock_tap_gen
`default_nettype wire

// [bench/pin_source.sv]
// Purpose: External pulse and window source for the counter input pin.
// Assumes: Pin is idle low between pulses.
// Notes: Widths below three hclk cycles are stretched to stay legal.
`timescale 1ns/1ps
`default_nettype none
module pin_source
(
	input wire logic hclk,
	output logic pin
);
	initial pin = 1'b0;
	task automatic pulse(input int hi, input int lo);
		int h;
		int l;
		h = (hi < 3) ? 3 : hi;
		l = (lo < 3) ? 3 : lo;
		@(posedge hclk);
		pin <= 1'b1;
		repeat (h) @(posedge hclk);
		pin <= 1'b0;
		repeat (l) @(posedge hclk);
	endtask
endmodule // pin_source
`default_nettype wire

// [bench/tb.sv]
// Purpose: Self-checking bench for the 16-bit timer/event/window counter.
// Assumes: AHB-Lite single word transfers; one slave drives hready.
// Notes: Periods are measured between match pulses, so prescaler phase does not matter.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import tc16_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic stop_mode_req = 1'b0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic pin;
	logic irq;
	int bad_count = 0;
	int tests_run = 0;
	int irq_n = 0;
	int cycles = 0;
	logic [31:0] rd;
	int g;
	int n0;
	// Reference model of what software sees, kept from the rules alone
	int m_ctrl = 0;
	int m_pwr = 0;
	int m_cmp = CMP_RESET;
	int m_lo_q[$];
	always #25 hclk = ~hclk;
	pin_source src_u (.hclk(hclk), .pin(pin));
	tc16_timer dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .stop_mode_req(stop_mode_req),
		.counter_input_pin(pin), .compare_match_irq(irq));
	always @(posedge hclk)
	begin
		cycles <= cycles + 1;
		if (irq === 1'b1)
			irq_n <= irq_n + 1;
		if (cycles == 40000)
		begin
			bad_count = bad_count + 1;
			conclude();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run = tests_run + 1;
		if (seen !== exp)
		begin
			bad_count = bad_count + 1;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Ready and data are looked at on the falling edge, so the value is the one the next rising edge samples
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
		logic ok;
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do
		begin
			@(negedge hclk);
			ok = hreadyout;
			@(posedge hclk);
		end
		while (ok !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do
		begin
			@(negedge hclk);
			ok = hreadyout;
			r = hrdata;
			check("hresp", {31'h0, hresp}, 32'h0);
			@(posedge hclk);
		end
		while (ok !== 1'b1);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic warm_cfg;
		warm_cfg = ((m_ctrl & 32'h1D) == 32'h10) && ((m_pwr & 3) == 2);
		bus(a, 1'b1, d, rd);
		if (a == CTRL_ADDR)
			m_ctrl = d;
		else if (a == PWR_ADDR)
			m_pwr = d;
		else if (a == CMP_LO_ADDR)
		begin
			// A second low byte replaces the parked one
			m_lo_q.delete();
			m_lo_q.push_back(d[7:0]);
		end
		else if (a == CMP_HI_ADDR && m_lo_q.size() > 0)
			m_cmp = {d[7:0], 8'(m_lo_q.pop_front())};
		else if (a == CMP_HI_ADDR && warm_cfg)
			m_cmp = {d[7:0], 8'(m_cmp)};
	endtask
	function automatic logic [31:0] m_reg(input logic [7:0] a);
		case (a)
			CTRL_ADDR: m_reg = m_ctrl & 32'h0000003D;
			CMP_LO_ADDR: m_reg = m_cmp & 32'h000000FF;
			CMP_HI_ADDR: m_reg = (m_cmp >> 8) & 32'h000000FF;
			PWR_ADDR: m_reg = m_pwr & 32'h00000007;
			default: m_reg = 32'h00000000;
		endcase
	endfunction
	// Cycles between matches in timer mode, normal state with tap 0 or the warm-up setting
	function automatic int m_period();
		int code;
		code = (m_ctrl >> 2) & 7;
		if ((m_ctrl & 32'h1D) == 32'h10 && (m_pwr & 3) == 2)
			m_period = (m_cmp >> 11) << 11;
		else
			case (code)
				0: m_period = m_cmp * 2048;
				1: m_period = m_cmp * 128;
				2: m_period = m_cmp * 32;
				3: m_period = m_cmp * 8;
				5: m_period = m_cmp * 610;
				default: m_period = 0;
			endcase
	endfunction
	task automatic mchk(input string what, input logic [7:0] a);
		rdchk(what, a, m_reg(a));
	endtask
	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 32'h0, rd);
		check(what, rd, exp);
	endtask
	task automatic setcmp(input logic [15:0] v);
		wr(CMP_LO_ADDR, {24'h0, v[7:0]});
		wr(CMP_HI_ADDR, {24'h0, v[15:8]});
	endtask
	// Cycles from one match pulse to the next
	task automatic gap(output int n);
		do @(negedge hclk); while (irq !== 1'b1);
		n = 0;
		do
		begin
			@(negedge hclk);
			n = n + 1;
		end
		while (irq !== 1'b1);
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(32'h291B));
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		mchk("ctrl reset", CTRL_ADDR);
		mchk("cmp lo reset", CMP_LO_ADDR);
		mchk("cmp hi reset", CMP_HI_ADDR);
		rdchk("count reset", COUNT_ADDR, 32'h0);
		rdchk("unmapped", 8'h20, 32'h0);
		$display("test reset done");
		wr(CMP_LO_ADDR, 32'h03);
		mchk("lone low", CMP_LO_ADDR);
		setcmp(16'h0003);
		wr(CTRL_ADDR, 32'h2C);
		mchk("ctrl back", CTRL_ADDR);
		gap(g);
		check("timer period", g, m_period());
		wr(CMP_LO_ADDR, 32'h05);
		gap(g);
		check("old compare", g, m_period());
		wr(CMP_HI_ADDR, 32'h00);
		gap(g);
		check("new compare", g, m_period());
		wr(CMP_HI_ADDR, 32'h01);
		mchk("lone high", CMP_HI_ADDR);
		$display("test timer done");
		@(posedge hclk);
		stop_mode_req <= 1'b1;
		m_ctrl = m_ctrl & ~32'h20;
		@(posedge hclk);
		stop_mode_req <= 1'b0;
		mchk("stop ctrl", CTRL_ADDR);
		rdchk("stop count", COUNT_ADDR, 32'h0);
		$display("test stop done");
		setcmp(16'h0002);
		wr(CTRL_ADDR, 32'h1C);
		wr(CTRL_ADDR, 32'h3C);
		n0 = irq_n;
		repeat (4) src_u.pulse($urandom_range(10, 3), $urandom_range(10, 3));
		repeat (6) @(posedge hclk);
		check("event matches", irq_n - n0, 32'd2);
		rdchk("event count", COUNT_ADDR, 32'h0);
		src_u.pulse(4, 4);
		rdchk("one edge", COUNT_ADDR, 32'h1);
		wr(CTRL_ADDR, 32'h1C);
		$display("test event done");
		setcmp(16'hFFFF);
		wr(CTRL_ADDR, 32'h0D);
		wr(CTRL_ADDR, 32'h2D);
		src_u.pulse(80, 3);
		bus(COUNT_ADDR, 1'b0, 32'h0, rd);
		check("window count", {31'h0, rd >= 9 && rd <= 11}, 32'h1);
		n0 = rd;
		repeat (40) @(posedge hclk);
		rdchk("window closed", COUNT_ADDR, n0);
		wr(CTRL_ADDR, 32'h0D);
		$display("test window done");
		wr(PWR_ADDR, 32'h02);
		mchk("power back", PWR_ADDR);
		wr(CTRL_ADDR, 32'h10);
		wr(CMP_HI_ADDR, 32'h10);
		wr(CTRL_ADDR, 32'h30);
		gap(g);
		check("warm up period", g, m_period());
		$display("test warm up done");
		conclude();
	end
endmodule // tb
`default_nettype wire
